/* File: hdl/eal_ctrl.sv */
// register bank and digital lead-off, gpio and leg-drive control
// assumes serial-interface logic on clk_in issues single-cycle register requests
// What this block does
// - calibration bit 7 enables offset calibration
// - bit 1 selects internal leg reference
// - direction bits: 0 output, 1 input
// - reads return actual gpio pin levels
// - data writes drive only output pins
// - mux 0110/0111 routes leg pin to input
// - ac excitation toggles at data rate/4
// - comparator outputs stored, sent in stream
// - 3-bit threshold selects 4-bit dac level
// - leg comparator uses same threshold bits
// - power-down bit disables lead-off comparators
// - flip bit swaps source and sink
// - 2-bit field sets excitation current
// - per-channel sensing, excitation can be off
// - leg amp on: no current, comparator only
// - status 1 means electrode disconnected
`timescale 1ns/1ps
module eal_ctrl import eal_pkg::*; #(
	parameter int AC_DIV = EAL_AC_DIV
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire eal_req_t req_in,
	input wire logic drdy_in,
	input wire logic ac_mode_in,
	input wire logic [4:0] comp_in,
	input wire logic [1:0] gpio_pin_in,
	output logic [1:0] gpio_pin_out,
	output logic [1:0] gpio_oe_out,
	output logic [7:0] rdata_out,
	output logic rvalid_out,
	output logic [4:0] stat_stream_out,
	output eal_ctrl_t ctrl_out
);
	initial begin
		if (AC_DIV != 4) $error("ac divide must be 4");
	end

	eal_state_t s;
	eal_state_t next_s;
	eal_ctrl_t c;
	eal_ctrl_t next_c;

	always_comb begin
		next_s = s;
		next_s.rvalid = 1'b0;
		next_s.pin_s1 = gpio_pin_in;
		next_s.pin_s2 = s.pin_s1;
		next_s.cmp_s1 = comp_in;
		next_s.cmp_s2 = s.cmp_s1;
		// comparator capture, gated by power-down; 1 = electrode off
		if (s.cfg2[EAL_PDCOMP_BIT]) begin
			next_s.stat = 5'h00;
		end else begin
			next_s.stat = s.cmp_s2;
		end
		// ac excitation phase, flips every AC_DIV/2 conversions
		if (drdy_in) begin
			next_s.ac_cnt = s.ac_cnt + 2'h1;
			if (s.ac_cnt[0]) begin
				next_s.ac_phase = ~s.ac_phase;
			end
		end
		if (req_in.wr) begin
			case (req_in.addr)
				EAL_OFS_MISC_CONTROL_TWO: next_s.misc_control_two = req_in.wdata & 8'h82;
				EAL_OFS_GPIO: begin
					next_s.gpio[3:2] = req_in.wdata[3:2];
					for (int i = 0; i < 2; i++) begin
						if (!req_in.wdata[EAL_DIR_LSB + i]) begin
							next_s.gpio[i] = req_in.wdata[i];
						end
					end
				end
				EAL_OFS_LOFF: next_s.loff = req_in.wdata;
				EAL_OFS_SENS: next_s.sens = req_in.wdata & 8'h3f;
				EAL_OFS_CFG2: next_s.cfg2 = req_in.wdata;
				EAL_OFS_CH1: next_s.ch1 = req_in.wdata;
				EAL_OFS_CH2: next_s.ch2 = req_in.wdata;
				EAL_OFS_LEG: next_s.leg = req_in.wdata & 8'h3f;
				default: ;
			endcase
		end
		if (req_in.rd) begin
			next_s.rvalid = 1'b1;
			case (req_in.addr)
				EAL_OFS_MISC_CONTROL_TWO: next_s.rdata = s.misc_control_two;
				EAL_OFS_GPIO: next_s.rdata = {4'h0, s.gpio[3:2], s.pin_s2};
				EAL_OFS_LOFF: next_s.rdata = s.loff;
				EAL_OFS_STAT: next_s.rdata = {3'h0, s.stat};
				EAL_OFS_SENS: next_s.rdata = s.sens;
				EAL_OFS_CFG2: next_s.rdata = s.cfg2;
				EAL_OFS_CH1: next_s.rdata = s.ch1;
				EAL_OFS_CH2: next_s.rdata = s.ch2;
				EAL_OFS_LEG: next_s.rdata = s.leg;
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	always_comb begin
		logic src;
		logic snk;
		logic flip;
		next_c = '0;
		src = 1'b0;
		snk = 1'b0;
		flip = 1'b0;
		next_c.cal_en = s.misc_control_two[EAL_CAL_BIT];
		next_c.ref_int = s.misc_control_two[EAL_REFINT_BIT];
		next_c.ch_pos_leg[0] = s.ch1[3:0] == EAL_MUX_LEG_POS;
		next_c.ch_neg_leg[0] = s.ch1[3:0] == EAL_MUX_LEG_NEG;
		next_c.ch_pos_leg[1] = s.ch2[3:0] == EAL_MUX_LEG_POS;
		next_c.ch_neg_leg[1] = s.ch2[3:0] == EAL_MUX_LEG_NEG;
		next_c.comp_pd = s.cfg2[EAL_PDCOMP_BIT];
		next_c.dac_level = {1'b0, s.loff[7:5]};
		next_c.cur_mag = s.loff[1:0];
		next_c.sense_en = s.sens[3:0];
		for (int i = 0; i < 4; i++) begin
			// p side sources, n side sinks; flip and ac phase 0 each reverse it
			flip = s.sens[4 + i / 2];
			src = (i % 2 == 0) ^ flip;
			if (ac_mode_in) begin
				src = s.ac_phase ^ (i % 2 == 1) ^ flip;
			end
			snk = ~src;
			// excitation off when internal source bit clear
			next_c.src_en[i] = s.sens[i] & s.loff[4] & src;
			next_c.sink_en[i] = s.sens[i] & s.loff[4] & snk;
		end
		next_c.leg_src_en = s.leg[EAL_LEGSENS_BIT] & ~s.leg[EAL_LEGPWR_BIT];
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			s <= '0;
			s.misc_control_two <= EAL_MISC_CONTROL_TWO_RST;
			s.gpio <= EAL_GPIO_RST;
			s.loff <= EAL_LOFF_RST;
			s.sens <= EAL_SENS_RST;
			s.cfg2 <= EAL_CFG2_RST;
			s.ch1 <= EAL_CH_RST;
			s.ch2 <= EAL_CH_RST;
			s.leg <= EAL_LEG_RST;
			c <= '0;
			gpio_pin_out <= 2'h0;
			gpio_oe_out <= 2'h0;
			stat_stream_out <= 5'h00;
		end else begin
			s <= next_s;
			c <= next_c;
			gpio_pin_out <= next_s.gpio[1:0];
			gpio_oe_out <= ~next_s.gpio[3:2];
			stat_stream_out <= next_s.stat;
		end
	end

	assign rdata_out = s.rdata;
	assign rvalid_out = s.rvalid;
	assign ctrl_out = c;
endmodule : eal_ctrl

/* File: hdl/eal_pkg.sv */
// package of constants and carrier types for the lead-off and gpio control block
// assumes a register write/read port supplied by the serial interface logic
package eal_pkg;
	localparam logic [7:0] EAL_OFS_MISC_CONTROL_TWO = 8'h0a;
	localparam logic [7:0] EAL_OFS_GPIO = 8'h0b;
	localparam logic [7:0] EAL_OFS_LOFF = 8'h04;
	localparam logic [7:0] EAL_OFS_STAT = 8'h08;
	localparam logic [7:0] EAL_OFS_SENS = 8'h07;
	localparam logic [7:0] EAL_OFS_CFG2 = 8'h02;
	localparam logic [7:0] EAL_OFS_CH1 = 8'h0c;
	localparam logic [7:0] EAL_OFS_CH2 = 8'h0d;
	localparam logic [7:0] EAL_OFS_LEG = 8'h0e;
	localparam int EAL_CAL_BIT = 7;
	localparam int EAL_REFINT_BIT = 1;
	localparam int EAL_DIR_LSB = 2;
	localparam int EAL_PDCOMP_BIT = 6;
	localparam int EAL_LEGPWR_BIT = 5;
	localparam int EAL_LEGSENS_BIT = 4;
	localparam logic [7:0] EAL_MISC_CONTROL_TWO_RST = 8'h00;
	localparam logic [7:0] EAL_GPIO_RST = 8'h0c;
	localparam logic [7:0] EAL_LOFF_RST = 8'h00;
	localparam logic [7:0] EAL_SENS_RST = 8'h00;
	localparam logic [7:0] EAL_CFG2_RST = 8'h00;
	localparam logic [7:0] EAL_CH_RST = 8'h00;
	localparam logic [7:0] EAL_LEG_RST = 8'h00;
	localparam logic [3:0] EAL_MUX_LEG_POS = 4'h6;
	localparam logic [3:0] EAL_MUX_LEG_NEG = 4'h7;
	localparam int EAL_AC_DIV = 4;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} eal_req_t;

	typedef struct packed {
		logic [7:0] misc_control_two;
		logic [7:0] gpio;
		logic [7:0] loff;
		logic [7:0] sens;
		logic [7:0] cfg2;
		logic [7:0] ch1;
		logic [7:0] ch2;
		logic [7:0] leg;
		logic [4:0] stat;
		logic [1:0] pin_s1;
		logic [1:0] pin_s2;
		logic [4:0] cmp_s1;
		logic [4:0] cmp_s2;
		logic [1:0] ac_cnt;
		logic ac_phase;
		logic [7:0] rdata;
		logic rvalid;
	} eal_state_t;

	typedef struct packed {
		logic cal_en;
		logic ref_int;
		logic [1:0] ch_pos_leg;
		logic [1:0] ch_neg_leg;
		logic comp_pd;
		logic [3:0] dac_level;
		logic [1:0] cur_mag;
		logic [3:0] src_en;
		logic [3:0] sink_en;
		logic [3:0] sense_en;
		logic leg_src_en;
	} eal_ctrl_t;
endpackage : eal_pkg

/* File: test/eal_host.sv */
// host register master model
// assumes requests are taken on rising clk_in edges
`timescale 1ns/1ps
module eal_host import eal_pkg::*; (
	input wire logic clk_in,
	output eal_req_t req_out
);
	initial req_out = '0;
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req_out <= '{w, ~w, a, d & (a == EAL_OFS_MISC_CONTROL_TWO ? 8'h82 : 8'hff)};
		@(posedge clk_in);
		req_out <= '0;
	endtask : acc
endmodule : eal_host

/* File: test/eal_ctrl_checker.sv */
// port assertions for the control block
// assumes one clock domain, bound to eal_ctrl
`timescale 1ns/1ps
module eal_ctrl_checker import eal_pkg::*; (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire eal_req_t req_in,
	input wire logic [1:0] gpio_oe_out,
	input wire logic [7:0] rdata_out,
	input wire logic rvalid_out,
	input wire logic [4:0] stat_stream_out,
	input wire eal_ctrl_t ctrl_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	sequence wr_to(logic [7:0] a);
		req_in.wr && req_in.addr == a;
	endsequence
	sequence rd_of(logic [7:0] a);
		req_in.rd && req_in.addr == a;
	endsequence
	rd_answer_a: assert property (req_in.rd |=> rvalid_out) else $error("no answer");
	rvalid_cause_a: assert property (rvalid_out |-> $past(req_in.rd)) else $error("stray");
	cal_follow_a: assert property (wr_to(EAL_OFS_MISC_CONTROL_TWO) |-> ##2
		ctrl_out.cal_en == $past(req_in.wdata[7], 2)) else $error("cal");
	ref_follow_a: assert property (wr_to(EAL_OFS_MISC_CONTROL_TWO) |-> ##2
		ctrl_out.ref_int == $past(req_in.wdata[1], 2)) else $error("ref");
	pin_dir_a: assert property (wr_to(EAL_OFS_GPIO) |=>
		gpio_oe_out == ~$past(req_in.wdata[3:2])) else $error("dir");
	misc_mask_a: assert property (rd_of(EAL_OFS_MISC_CONTROL_TWO) |=>
		rdata_out[6:2] == 5'h00 && !rdata_out[0]) else $error("mask");
	dac_follow_a: assert property (wr_to(EAL_OFS_LOFF) |-> ##2
		ctrl_out.dac_level == {1'b0, $past(req_in.wdata[7:5], 2)}) else $error("dac");
	pd_follow_a: assert property (wr_to(EAL_OFS_CFG2) |-> ##2
		ctrl_out.comp_pd == $past(req_in.wdata[6], 2)) else $error("pd");
	pd_status_a: assert property (ctrl_out.comp_pd |-> stat_stream_out == 5'h00) else $error("pd status");
	leg_power_a: assert property (wr_to(EAL_OFS_LEG) ##0 req_in.wdata[5] |-> ##2
		!ctrl_out.leg_src_en) else $error("leg source");
endmodule : eal_ctrl_checker
bind eal_ctrl eal_ctrl_checker u_chk (.clk_in, .nrst_in, .req_in, .gpio_oe_out, .rdata_out,
	.rvalid_out, .stat_stream_out, .ctrl_out);

/* File: test/testbench.sv */
// self-checking bench for the control block
// assumes eal_host model; external pins resolved here
`timescale 1ns/1ps
module testbench import eal_pkg::*;;
	logic clk_in = 0, nrst_in = 0, drdy_in = 0, ac_mode_in = 0;
	logic [4:0] comp_in = '0, stat_stream_out;
	logic [1:0] ext_pins = 2'h2, gpio_pin_out, gpio_oe_out;
	logic [7:0] rdata_out;
	logic rvalid_out;
	eal_ctrl_t ctrl_out;
	eal_req_t req;
	wire logic [1:0] lvl = (gpio_oe_out & gpio_pin_out) | (~gpio_oe_out & ext_pins);
	int n_fail = 0, num_checks = 0;
	eal_host u_host (.clk_in, .req_out(req));
	eal_ctrl u_dut (.clk_in, .nrst_in, .req_in(req), .drdy_in, .ac_mode_in, .comp_in,
		.gpio_pin_in(lvl), .gpio_pin_out, .gpio_oe_out, .rdata_out, .rvalid_out,
		.stat_stream_out, .ctrl_out);
	initial forever #2 clk_in = ~clk_in;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.acc(1'b1, a, d);
		repeat (3) @(posedge clk_in);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		u_host.acc(1'b0, a, 8'h00);
		#1 chk(rvalid_out === 1'b1 ? rdata_out : 8'hxx, exp);
	endtask : rd
	task automatic pulse;
		drdy_in <= 1;
		@(posedge clk_in);
		drdy_in <= 0;
		repeat (3) @(posedge clk_in);
	endtask : pulse
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (12) @(posedge clk_in);
		nrst_in <= 1;
		rd(EAL_OFS_MISC_CONTROL_TWO, EAL_MISC_CONTROL_TWO_RST);
		rd(EAL_OFS_GPIO, 8'h0e);
		wr(EAL_OFS_MISC_CONTROL_TWO, 8'h82);
		rd(EAL_OFS_MISC_CONTROL_TWO, 8'h82);
		chk({6'h0, ctrl_out.cal_en, ctrl_out.ref_int}, 8'h03);
		wr(EAL_OFS_GPIO, 8'h01);
		chk({4'h0, gpio_oe_out, gpio_pin_out}, 8'h0d);
		rd(EAL_OFS_GPIO, 8'h01);
		wr(EAL_OFS_GPIO, 8'h0e);
		chk({4'h0, gpio_oe_out, gpio_pin_out}, 8'h01);
		rd(EAL_OFS_GPIO, 8'h0e);
		wr(EAL_OFS_CH1, 8'h06);
		wr(EAL_OFS_CH2, 8'h07);
		chk({4'h0, ctrl_out.ch_pos_leg, ctrl_out.ch_neg_leg}, 8'h06);
		wr(EAL_OFS_LOFF, 8'ha0);
		comp_in <= 5'h15;
		repeat (4) @(posedge clk_in);
		drdy_in <= 1;
		@(posedge clk_in);
		drdy_in <= 0;
		repeat (4) @(posedge clk_in);
		chk({3'h0, stat_stream_out}, 8'h15);
		rd(EAL_OFS_STAT, 8'h15);
		wr(EAL_OFS_CFG2, 8'h40);
		chk({3'h0, stat_stream_out}, 8'h00);
		rd(EAL_OFS_STAT, 8'h00);
		wr(EAL_OFS_LOFF, 8'hb2);
		chk({6'h0, ctrl_out.cur_mag}, 8'h02);
		wr(EAL_OFS_SENS, 8'h0f);
		chk({ctrl_out.src_en, ctrl_out.sink_en}, 8'h5a);
		wr(EAL_OFS_SENS, 8'h1f);
		chk({ctrl_out.src_en, ctrl_out.sink_en}, 8'h69);
		wr(EAL_OFS_SENS, 8'h0f);
		ac_mode_in <= 1;
		repeat (4) @(posedge clk_in);
		chk({ctrl_out.src_en, ctrl_out.sink_en}, 8'ha5);
		pulse;
		chk({ctrl_out.src_en, ctrl_out.sink_en}, 8'h5a);
		pulse;
		chk({ctrl_out.src_en, ctrl_out.sink_en}, 8'h5a);
		pulse;
		chk({ctrl_out.src_en, ctrl_out.sink_en}, 8'ha5);
		ac_mode_in <= 0;
		wr(EAL_OFS_LEG, 8'h10);
		chk({7'h0, ctrl_out.leg_src_en}, 8'h01);
		wr(EAL_OFS_LEG, 8'h30);
		chk({7'h0, ctrl_out.leg_src_en}, 8'h00);
		rd(8'h3f, 8'h00);
		tally_and_finish;
	end
	initial begin
		repeat (3000) @(posedge clk_in);
		n_fail++;
		tally_and_finish;
	end
endmodule : testbench
